/* src/comparator_opamp_control.sv */
// Top: comparator and op-amp control with Wishbone slave and interrupt
`timescale 1ns/1ps
module comparator_opamp_control
  import cmp_amp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // Wishbone classic slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // Analog comparator side
  input  wire logic              comparator_raw_i,
  output logic                   comparator_on_o,
  output logic                   negative_input_choice_o,
  output logic                   fault_o,
  // Analog amplifier side
  input  wire logic              amplifier_raw_i,
  input  wire logic              schmitt_on_i,
  output logic                   amplifier_on_o,
  output logic                   amplifier_out_pin_oe_o,
  output logic                   amplifier_level_o,
  // Interrupt
  output logic                   irq_o
);

  cmp_sync_if cmp ();

  logic         comp_on;
  logic         amp_on;
  logic         neg_sel;
  edge_choice_t edge_sel;
  logic         polarity;
  logic         req;
  logic         hit_ctrl;
  logic         hit_status;
  logic         hit_mask;
  logic         ctrl_wr;
  logic         edge_ev;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] status_reg;
  logic [EV_W-1:0] mask_reg;
  logic [EV_W-1:0] status_next;
  logic [7:0]      ctrl_view;
  logic [31:0]     rd_next;
  logic            status_wr;
  logic            mask_wr;
  logic [SYNC_STAGES-1:0] amp_sync_reg;

  // Only byte lane 0 carries register bits; other lanes are ignored
  function automatic logic low_byte_write(input logic       take,
                                          input logic       write,
                                          input logic [3:0] lanes,
                                          input logic       hit);
    low_byte_write = take & write & lanes[0] & hit;
  endfunction : low_byte_write

  // Request is taken only when no ack is pending, giving one-cycle acks
  assign req        = cyc_i & stb_i & ~ack_o & ce_i;
  assign hit_ctrl   = addr_hit(adr_i, CTRL_ADDR);
  assign hit_status = addr_hit(adr_i, STATUS_ADDR);
  assign hit_mask   = addr_hit(adr_i, MASK_ADDR);
  assign ctrl_wr    = low_byte_write(req, we_i, sel_i, hit_ctrl);
  assign status_wr  = low_byte_write(req, we_i, sel_i, hit_status);
  assign mask_wr    = low_byte_write(req, we_i, sel_i, hit_mask);

  cmp_level_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .raw_i (comparator_raw_i),
    .sync  (cmp.src)
  );

  cmp_amp_regs u_regs (
    .clk_i                   (clk_i),
    .rst_i                   (rst_i),
    .ce_i                    (ce_i),
    .wr_i                    (ctrl_wr),
    .wdata_i                 (dat_i[7:0]),
    .comparator_on_o         (comp_on),
    .amplifier_on_o          (amp_on),
    .negative_input_choice_o (neg_sel),
    .irq_edge_choice_o       (edge_sel),
    .fault_polarity_o        (polarity)
  );

  assign edge_ev = (edge_sel == EDGE_RISING) ? cmp.rise : cmp.fall;
  // Gated by the enable: a powered-down comparator raises nothing
  assign ev_set[EV_EDGE_BIT]   = comp_on & edge_ev;
  assign ev_set[EV_CHANGE_BIT] = comp_on & (cmp.rise | cmp.fall);

  // Set wins over a write-one clear in the same cycle
  always_comb begin
    status_next = status_reg;
    if (status_wr) begin
      status_next = status_reg & ~dat_i[EV_W-1:0];
    end
    status_next = status_next | ev_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= EV_RESET;
    end else if (ce_i) begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= EV_RESET;
    end else if (mask_wr) begin
      mask_reg <= dat_i[EV_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(status_next & mask_reg);
    end
  end

  always_comb begin
    ctrl_view               = 8'h00;
    ctrl_view[COMP_ON_BIT]  = comp_on;
    ctrl_view[LEVEL_BIT]    = cmp.level;
    ctrl_view[POLARITY_BIT] = polarity;
    ctrl_view[EDGE_BIT]     = edge_sel;
    ctrl_view[NEG_SEL_BIT]  = neg_sel;
    ctrl_view[AMP_ON_BIT]   = amp_on;
  end

  // Unmapped addresses still ack and read zero, so the bus never hangs
  always_comb begin
    rd_next = READ_ZERO;
    if (hit_ctrl) begin
      rd_next[7:0] = ctrl_view;
    end else if (hit_status) begin
      rd_next[EV_W-1:0] = status_reg;
    end else if (hit_mask) begin
      rd_next[EV_W-1:0] = mask_reg;
    end
  end

  // One-cycle answer; ack high blocks a second take of the same request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else if (ce_i) begin
      ack_o <= req;
    end
  end

  // Read data stands only with its ack, zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= READ_ZERO;
    end else if (ce_i) begin
      dat_o <= req ? rd_next : READ_ZERO;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comparator_on_o <= 1'b0;
    end else if (ce_i) begin
      comparator_on_o <= comp_on;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amplifier_on_o <= 1'b0;
    end else if (ce_i) begin
      amplifier_on_o <= amp_on;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      negative_input_choice_o <= 1'b0;
    end else if (ce_i) begin
      negative_input_choice_o <= neg_sel;
    end
  end

  // pin drives only while amplifier on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amplifier_out_pin_oe_o <= 1'b0;
    end else if (ce_i) begin
      amplifier_out_pin_oe_o <= amp_on;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_o <= 1'b0;
    end else if (ce_i) begin
      fault_o <= comp_on & (cmp.level ^ polarity);
    end
  end

  // Amplifier level is asynchronous too; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amp_sync_reg <= '0;
    end else if (ce_i) begin
      amp_sync_reg <= {amp_sync_reg[SYNC_STAGES-2:0], amplifier_raw_i};
    end
  end

  // level visible only when both enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amplifier_level_o <= 1'b0;
    end else if (ce_i) begin
      amplifier_level_o <= amp_on & schmitt_on_i & amp_sync_reg[SYNC_STAGES-1];
    end
  end

endmodule : comparator_opamp_control

/* src/cmp_amp_pkg.sv */
// Package: register map, field positions and reset values for the block
package cmp_amp_pkg;

  // Register byte offsets (documented control register, own status/mask)
  localparam logic [23:0] CTRL_ADDR   = 24'hFFE510;
  localparam logic [23:0] STATUS_ADDR = 24'hFFE514;
  localparam logic [23:0] MASK_ADDR   = 24'hFFE518;
  localparam int          ADDR_W      = 24;

  // Control register field positions
  localparam int COMP_ON_BIT    = 0;
  localparam int LEVEL_BIT      = 1;
  localparam int POLARITY_BIT   = 2;
  localparam int EDGE_BIT       = 3;
  localparam int NEG_SEL_BIT    = 4;
  localparam int AMP_ON_BIT     = 7;

  // Status and mask field positions
  localparam int EV_EDGE_BIT    = 0;
  localparam int EV_CHANGE_BIT  = 1;
  localparam int EV_W           = 2;

  // Reset values
  localparam logic [7:0]      CTRL_RESET  = 8'h00;
  localparam logic [EV_W-1:0] EV_RESET    = 2'h0;
  localparam logic [31:0]     READ_ZERO   = 32'h0000_0000;

  // Synchroniser depth
  localparam int SYNC_STAGES = 2;

  // Edge-select encoding
  typedef enum logic {
    EDGE_RISING,
    EDGE_FALLING
  } edge_choice_t;

  // Word-aligned address compare
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] r);
    addr_hit = (a[ADDR_W-1:2] == r[ADDR_W-1:2]);
  endfunction : addr_hit

endpackage : cmp_amp_pkg

/* src/cmp_sync_if.sv */
// Interface: synchronised comparator level and its edge pulses
`timescale 1ns/1ps
interface cmp_sync_if;
  logic level;
  logic rise;
  logic fall;

  modport src (output level, output rise, output fall);
  modport dst (input  level, input  rise, input  fall);
endinterface : cmp_sync_if

/* src/cmp_level_sync.sv */
// Two-flop synchroniser with edge detection on the comparator output
`timescale 1ns/1ps
module cmp_level_sync
  import cmp_amp_pkg::*;
(
  // Clock and control
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  input  wire logic   ce_i,
  // Raw asynchronous level
  input  wire logic   raw_i,
  // Synchronised result
  cmp_sync_if.src     sync
);

  logic [SYNC_STAGES-1:0] stage_reg;
  logic                   last_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage_reg <= '0;
    end else if (ce_i) begin
      stage_reg <= {stage_reg[SYNC_STAGES-2:0], raw_i};
    end
  end

  // Only the last stage feeds the edge detector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_reg <= 1'b0;
    end else if (ce_i) begin
      last_reg <= stage_reg[SYNC_STAGES-1];
    end
  end

  assign sync.level = stage_reg[SYNC_STAGES-1];
  assign sync.rise  = ce_i & stage_reg[SYNC_STAGES-1] & ~last_reg;
  assign sync.fall  = ce_i & ~stage_reg[SYNC_STAGES-1] & last_reg;

endmodule : cmp_level_sync

/* src/cmp_amp_regs.sv */
// Control register storage with software-written fields
`timescale 1ns/1ps
module cmp_amp_regs
  import cmp_amp_pkg::*;
(
  // Clock and control
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // Write port
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  // Stored fields
  output logic            comparator_on_o,
  output logic            amplifier_on_o,
  output logic            negative_input_choice_o,
  output edge_choice_t    irq_edge_choice_o,
  output logic            fault_polarity_o
);

  logic [7:0] ctrl_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ce_i && wr_i) begin
      ctrl_reg <= wdata_i;
    end
  end

  assign comparator_on_o         = ctrl_reg[COMP_ON_BIT];
  assign amplifier_on_o          = ctrl_reg[AMP_ON_BIT];
  assign negative_input_choice_o = ctrl_reg[NEG_SEL_BIT];
  assign irq_edge_choice_o       = edge_choice_t'(ctrl_reg[EDGE_BIT]);
  assign fault_polarity_o        = ctrl_reg[POLARITY_BIT];

endmodule : cmp_amp_regs

/* verif/cmp_amp_monitor.sv */
// Checker: port assertions for the comparator control block
`timescale 1ns/1ps
module cmp_amp_monitor
  import cmp_amp_pkg::*;
(
  // Clock and bus
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              ce_i,
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic              we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0]        sel_i,
  input wire logic [31:0]       dat_i,
  input wire logic [31:0]       dat_o,
  input wire logic              ack_o,
  // Analog side
  input wire logic              comparator_raw_i,
  input wire logic              comparator_on_o,
  input wire logic              negative_input_choice_o,
  input wire logic              fault_o,
  input wire logic              schmitt_on_i,
  input wire logic              amplifier_on_o,
  input wire logic              amplifier_out_pin_oe_o,
  input wire logic              amplifier_level_o,
  input wire logic              irq_o
);
  logic       take;
  logic       wr_ctrl;
  logic       rd_ctrl;
  logic [1:0] up_reg;
  assign take = cyc_i && stb_i && !ack_o && ce_i;
  assign wr_ctrl = take && we_i && sel_i[0] &&
                   adr_i[23:2] == CTRL_ADDR[23:2];
  assign rd_ctrl = take && !we_i && adr_i[23:2] == CTRL_ADDR[23:2];
  // Synchroniser holds stale zeros for a few edges after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows: assert property (take |=> ack_o)
    else $error("request not acknowledged");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  // Register stage plus output flop: the pins follow a write by two edges
  a_comp_enable: assert property (
    wr_ctrl |=> ##1 comparator_on_o == $past(dat_i[0], 2))
    else $error("comparator enable not written");
  a_amp_enable: assert property (
    wr_ctrl |=> ##1 amplifier_on_o == $past(dat_i[7], 2))
    else $error("amplifier enable not written");
  a_neg_choice: assert property (
    wr_ctrl |=> ##1 negative_input_choice_o == $past(dat_i[4], 2))
    else $error("input choice not written");
  a_pin_float: assert property (
    !amplifier_on_o && !$past(amplifier_on_o) |-> !amplifier_out_pin_oe_o)
    else $error("pin driven while amplifier off");
  a_amp_level: assert property (
    amplifier_level_o |-> $past(schmitt_on_i) &&
      (amplifier_on_o || $past(amplifier_on_o)))
    else $error("amplifier level without enables");
  a_fault_off: assert property (
    !comparator_on_o && !$past(comparator_on_o) |-> !fault_o)
    else $error("fault while comparator off");
  a_reserved_zero: assert property (
    ack_o |-> dat_o[31:8] == 24'h0 && dat_o[6:5] == 2'h0)
    else $error("reserved bits not zero");
  a_level_read: assert property (
    rd_ctrl && up_reg == 2'h3 &&
    comparator_raw_i == $past(comparator_raw_i) &&
    comparator_raw_i == $past(comparator_raw_i, 2) &&
    comparator_raw_i == $past(comparator_raw_i, 3)
    |=> dat_o[1] == $past(comparator_raw_i))
    else $error("level bit wrong");
  c_write: cover property (wr_ctrl);
  c_fault: cover property (fault_o);
  c_irq: cover property (irq_o);
endmodule : cmp_amp_monitor

bind comparator_opamp_control cmp_amp_monitor mon_u (.*);

/* verif/cmp_amp_analog.sv */
// Model of the analog comparator and amplifier
`timescale 1ns/1ps
module cmp_amp_analog (
  // Pin voltages in millivolts
  input int              pos_mv_i,
  input int              neg_b_mv_i,
  input int              neg_c_mv_i,
  // Controls from the block, plus amp_high_i set by the testbench
  input wire logic       negative_input_choice_i,
  input wire logic       comparator_on_i,
  input wire logic       amp_oe_i,
  input wire logic       amp_high_i,
  // Digital results
  output logic           comparator_raw_o,
  output logic           amplifier_raw_o
);
  int neg_mv;
  assign neg_mv = negative_input_choice_i ? neg_c_mv_i : neg_b_mv_i;
  // high above reference, low when powered down
  assign comparator_raw_o = comparator_on_i && (pos_mv_i > neg_mv);
  // released pin falls to its pull-down
  assign amplifier_raw_o = amp_oe_i && amp_high_i;
endmodule : cmp_amp_analog

/* verif/testbench.sv */
// Testbench: register, interrupt and analog checks
`timescale 1ns/1ps
module testbench
  import cmp_amp_pkg::*;
;
  logic        clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0;
  logic        we_i = 0, schmitt_on_i = 0, amp_high = 0;
  logic [23:0] adr_i = 24'h0;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic        ack_o, comparator_raw_i, comparator_on_o, fault_o;
  logic        negative_input_choice_o, amplifier_raw_i, amplifier_on_o;
  logic        amplifier_out_pin_oe_o, amplifier_level_o, irq_o;
  int          pos = 400, nb = 500, nc = 500, errors = 0, checked = 0;

  always #5 clk_i = ~clk_i;
  comparator_opamp_control dut_u (.*);
  cmp_amp_analog model_u (.pos_mv_i(pos), .neg_b_mv_i(nb),
    .neg_c_mv_i(nc), .negative_input_choice_i(negative_input_choice_o),
    .comparator_on_i(comparator_on_o), .amp_oe_i(amplifier_out_pin_oe_o),
    .amp_high_i(amp_high), .comparator_raw_o(comparator_raw_i),
    .amplifier_raw_o(amplifier_raw_i));

  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [23:0] a, [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : bus

  task automatic rd(input logic [23:0] a, [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rd

  // Far-side level change, then time for the synchroniser
  task automatic lvl(input logic v);
    pos <= v ? 600 : 400;
    repeat (5) @(posedge clk_i);
  endtask : lvl

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    tally_and_finish;
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CTRL_ADDR, 32'h0, "ctrl");
    bus(1'b1, CTRL_ADDR, 32'hFF);
    rd(CTRL_ADDR, 32'h9D, "ctrl");
    chk("enables", 4'hF, {amplifier_on_o, amplifier_out_pin_oe_o,
      negative_input_choice_o, comparator_on_o});
    nb <= 300;
    nc <= 700;
    pos <= 500;
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, CTRL_ADDR, {27'h0, s == 1, 4'h1});
      repeat (4) @(posedge clk_i);
      rd(CTRL_ADDR, {27'h0, s == 1, 2'h0, s == 0, 1'b1}, "level");
    end
    nb <= 500;
    nc <= 500;
    lvl(1'b0);
    bus(1'b1, MASK_ADDR, 32'h1);
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, CTRL_ADDR, {28'h0, e == 1, 3'h1});
      bus(1'b1, STATUS_ADDR, 32'h3);
      lvl(1'b1);
      rd(STATUS_ADDR, {30'h0, 1'b1, e == 0}, "status");
      chk("irq", e == 0, irq_o);
      lvl(1'b0);
      rd(STATUS_ADDR, 32'h3, "status");
      bus(1'b1, STATUS_ADDR, 32'h3);
      rd(STATUS_ADDR, 32'h0, "status");
      chk("irq", 0, irq_o);
    end
    // Masked event stays silent until its mask bit opens
    bus(1'b1, MASK_ADDR, 32'h0);
    lvl(1'b1);
    chk("irq", 0, irq_o);
    bus(1'b1, MASK_ADDR, 32'h2);
    repeat (2) @(posedge clk_i);
    chk("irq", 1, irq_o);
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, CTRL_ADDR, {29'h0, p[1], 2'h1});
      lvl(p[0]);
      chk("fault", p[0] ^ p[1], fault_o);
    end
    // Clock enable low freezes the level path and the fault output
    ce_i <= 1'b0;
    lvl(1'b0);
    chk("frozen fault", 0, fault_o);
    ce_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("fault", 1, fault_o);
    bus(1'b1, CTRL_ADDR, 32'h4);
    lvl(1'b0);
    chk("fault", 0, fault_o);
    amp_high <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      bus(1'b1, CTRL_ADDR, {24'h0, a[1], 7'h0});
      schmitt_on_i <= a[0];
      repeat (4) @(posedge clk_i);
      chk("amp", {a[1], a[0] & a[1]},
        {amplifier_out_pin_oe_o, amplifier_level_o});
    end
    bus(1'b1, 24'hFFE51C, 32'hFF);
    rd(24'hFFE51C, 32'h0, "unmapped");
    rd(CTRL_ADDR, 32'h80, "ctrl");
    tally_and_finish;
  end
endmodule : testbench
